// ===== core/acis_map.svh
// Register map, field positions, reset values and code points of the input select block.
// Assumes an 8-bit register port; included by bare name wherever these constants are needed.
`ifndef ACIS_MAP_SVH
`define ACIS_MAP_SVH

// Register offsets
`define ACIS_OFF_CSRA       8'h06
`define ACIS_OFF_SEL        8'h07
`define ACIS_OFF_STAT       8'h08
`define ACIS_OFF_MASK       8'h09

// Reset values
`define ACIS_RST_CSRA       8'h00
`define ACIS_RST_SEL        8'h00
`define ACIS_RST_MASK       4'h0

// Control/status A bit positions
`define ACIS_CSRA_EN        7
`define ACIS_CSRA_BUSY      6
`define ACIS_CSRA_AUTO      5
`define ACIS_CSRA_DONE      4
`define ACIS_CSRA_IE        3

// Reference codes
`define ACIS_REF_VCC        2'h0
`define ACIS_REF_EXT        2'h1
`define ACIS_REF_INT        2'h2
`define ACIS_REF_INT_PIN    2'h3

// Special input codes
`define ACIS_SEL_AGND       6'h20
`define ACIS_SEL_IREF       6'h21
`define ACIS_SEL_TEMP       6'h22
`define ACIS_SEL_CAL0       6'h23

// Interrupt status bit positions
`define ACIS_EV_DONE        0
`define ACIS_EV_APPLY       1
`define ACIS_EV_ABORT       2
`define ACIS_EV_RSVREF      3

// Settling allowance after a new pair or reference, in converter clocks
`define ACIS_SETTLE_CYC     13
// Converter clock division at prescale code 000
`define ACIS_PRESC_DIV0     2

`endif

// ===== core/acis_pkg.sv
// Types shared by the input select block and its decoder.
// Assumes the map header for numeric constants; holds types only.
package acis_pkg;

  // Kind of source routed to the converter
  typedef enum logic [2:0] {
    acis_src_single = 3'b000,
    acis_src_agnd   = 3'b001,
    acis_src_iref   = 3'b010,
    acis_src_temp   = 3'b011,
    acis_src_diff   = 3'b100,
    acis_src_calib  = 3'b101
  } acis_src_t;

  // Whole register state of the top module
  typedef struct packed {
    logic       en;        // Converter powered
    logic       auto_bit;  // Stored only; leaves the block only through a read of control/status A
    logic       ie_bit;    // Stored only
    logic [2:0] presc;     // Stored only
    logic       done_flag; // Conversion finished
    logic [1:0] wr_ref;    // Written reference
    logic [5:0] wr_sel;    // Written input code
    logic [1:0] act_ref;   // Reference in use
    logic [5:0] act_sel;   // Input code in use
    acis_src_t  src;       // Decoded source kind
    logic [2:0] pos;       // Positive channel
    logic [2:0] neg;       // Negative channel
    logic       gain;      // High gain
    logic       ref_pin;   // Internal reference drives the pin
    logic       int_ref;   // Internal reference powered
    logic       ext_ref;   // External pin is the reference
    logic       temp_en;   // Temperature sensor powered
    logic [3:0] stat;      // Sticky events
    logic [3:0] mask;      // Event mask
    logic       irq;       // Interrupt level
    logic       abort;     // Abort pulse
    logic [7:0] rdata;     // Read data
  } acis_state_t;

endpackage

// ===== core/acis_decode.sv
// Input code decoder: turns a six-bit input code into source kind, channel pair and gain.
// Assumes a registered caller; purely combinational.
`timescale 1ns/1ps
`include "acis_map.svh"

module acis_decode (
  // Code in
  input  wire logic [5:0]         code,
  // Decoded selection
  output acis_pkg::acis_src_t     src,
  output logic [2:0]              pos_ch,
  output logic [2:0]              neg_ch,
  output logic                    gain
);
  import acis_pkg::*;

  // Normal pair for code bits 4:1, before any reversal
  logic [2:0] pair_p;  // Positive pin of the pair
  logic [2:0] pair_n;  // Negative pin of the pair

  // Pair table for the twelve normal differential pairs
  always_comb begin
    pair_p = 3'h0;
    pair_n = 3'h0;
    unique case (code[4:1])
      4'h4:    begin pair_p = 3'h0; pair_n = 3'h1; end
      4'h5:    begin pair_p = 3'h0; pair_n = 3'h3; end
      4'h6:    begin pair_p = 3'h1; pair_n = 3'h2; end
      4'h7:    begin pair_p = 3'h1; pair_n = 3'h3; end
      4'h8:    begin pair_p = 3'h2; pair_n = 3'h3; end
      4'h9:    begin pair_p = 3'h3; pair_n = 3'h4; end
      4'ha:    begin pair_p = 3'h3; pair_n = 3'h5; end
      4'hb:    begin pair_p = 3'h3; pair_n = 3'h6; end
      4'hc:    begin pair_p = 3'h3; pair_n = 3'h7; end
      4'hd:    begin pair_p = 3'h4; pair_n = 3'h5; end
      4'he:    begin pair_p = 3'h5; pair_n = 3'h6; end
      4'hf:    begin pair_p = 3'h6; pair_n = 3'h7; end
      // Codes 0..3 are not pairs; the caller never reads these
      default: begin pair_p = 3'h0; pair_n = 3'h0; end
    endcase
  end

  // Classify the code
  always_comb begin
    src    = acis_src_single;
    pos_ch = code[2:0];
    neg_ch = 3'h0;
    gain   = 1'b0;
    if (code[5:3] == 3'h0) begin
      src = acis_src_single;
    end else if (code == `ACIS_SEL_AGND) begin
      src = acis_src_agnd;
    end else if (code == `ACIS_SEL_IREF) begin
      src = acis_src_iref;
    end else if (code == `ACIS_SEL_TEMP) begin
      src = acis_src_temp;
    end else if (code[5:3] == 3'h4) begin
      // Same pin on both inputs, only pins 0, 3 and 7
      src    = acis_src_calib;
      pos_ch = (code[2:1] == 2'h1) ? 3'h0 : (code[2:1] == 2'h2) ? 3'h3 : 3'h7;
      neg_ch = pos_ch;
      gain   = code[0];
    end else begin
      src  = acis_src_diff;
      gain = code[0];
      // Top bit swaps the two inputs of a normal pair
      pos_ch = code[5] ? pair_n : pair_p;
      neg_ch = code[5] ? pair_p : pair_n;
    end
  end

endmodule

// ===== core/acis_top.sv
// Converter input and reference selection with the converter enable bit.
// Assumes a conversion engine on the same clock giving busy and a one-cycle done.
// Summary of operation
// - Reference code picks supply, pin or internal
// - Reference change waits for running conversion end
// - Input change waits for running conversion end
// - Code 11 drives internal reference onto pin
// - Codes 0 to 7 select single pins
// - Ground, internal reference, temperature sensor codes
// - Normal, calibration and reversed pair ranges
// - Lowest code bit picks 1x or 20x
// - Top code bit swaps pair polarity
// - Calibration ties one pin to both inputs
// - Each pair code maps to its pins
// - Enable bit powers converter, clearing aborts
// - Done flag sets when conversion finishes
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
`include "acis_map.svh"

module acis_top (
  // Clock and reset
  input  wire logic               core_clk,
  input  wire logic               resetn,
  // Register port
  input  wire logic [7:0]         reg_addr,
  input  wire logic [7:0]         reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic [7:0]              reg_rdata,
  // Conversion engine
  input  wire logic               conv_busy,
  input  wire logic               conv_done,
  output logic                    converter_enable,
  output logic                    conv_abort,
  // Reference control
  output logic [1:0]              reference_select,
  output logic                    ref_pin_drive,
  output logic                    int_ref_on,
  output logic                    ext_ref_sel,
  // Input routing
  output logic [5:0]              input_select,
  output acis_pkg::acis_src_t     src_kind,
  output logic [2:0]              pos_channel,
  output logic [2:0]              neg_channel,
  output logic                    gain_select_bit,
  output logic                    temp_sensor_en,
  // Interrupt
  output logic                    irq
);
  import acis_pkg::*;

  acis_state_t st;       // Registered state
  acis_state_t next_st;  // Next state

  // Decoded register accesses
  logic       wr_csra;   // Write to control/status A
  logic       wr_sel;    // Write to the select register
  logic       wr_mask;   // Write to the mask
  logic       rd_stat;   // Read of the event status
  logic [5:0] new_sel;   // Written input code after this cycle
  logic [1:0] new_ref;   // Written reference after this cycle
  logic       may_apply; // Active copies may follow written ones
  logic [5:0] use_sel;   // Input code in use after this cycle
  logic [1:0] use_ref;   // Reference in use after this cycle

  // Decoder outputs for the next active code
  acis_src_t  dec_src;
  logic [2:0] dec_pos;
  logic [2:0] dec_neg;
  logic       dec_gain;

  // Address decode
  assign wr_csra = reg_wr && (reg_addr == `ACIS_OFF_CSRA);
  assign wr_sel  = reg_wr && (reg_addr == `ACIS_OFF_SEL);
  assign wr_mask = reg_wr && (reg_addr == `ACIS_OFF_MASK);
  assign rd_stat = reg_rd && (reg_addr == `ACIS_OFF_STAT);

  // Written copies take a register write at once
  assign new_sel = wr_sel ? reg_wdata[5:0] : st.wr_sel;
  assign new_ref = wr_sel ? reg_wdata[7:6] : st.wr_ref;

  // Idle or finishing: a write in the done cycle lands after the conversion anyway
  // An aborted conversion leaves a pending write, applied once busy falls
  assign may_apply = !conv_busy || conv_done;
  assign use_sel   = may_apply ? new_sel : st.act_sel;
  assign use_ref   = may_apply ? new_ref : st.act_ref;

  // Decode the code that will be active next, so outputs come from flops
  acis_decode u_decode (
    .code   (use_sel),
    .src    (dec_src),
    .pos_ch (dec_pos),
    .neg_ch (dec_neg),
    .gain   (dec_gain)
  );

  // Next-state logic
  always_comb begin
    next_st = st;
    next_st.abort = 1'b0;
    next_st.rdata = 8'h00;

    // Control/status A write
    if (wr_csra) begin
      next_st.en       = reg_wdata[`ACIS_CSRA_EN];
      next_st.auto_bit = reg_wdata[`ACIS_CSRA_AUTO];
      next_st.ie_bit   = reg_wdata[`ACIS_CSRA_IE];
      next_st.presc    = reg_wdata[2:0];
      // Clearing the enable mid-conversion kills that conversion
      if (st.en && !reg_wdata[`ACIS_CSRA_EN] && conv_busy && !conv_done) begin
        next_st.abort = 1'b1;
      end
      // Done flag is write-one-to-clear
      if (reg_wdata[`ACIS_CSRA_DONE]) begin
        next_st.done_flag = 1'b0;
      end
    end
    // Completion sets the flag; the set wins over a same-cycle clear
    if (conv_done) begin
      next_st.done_flag = 1'b1;
    end

    // Written and active selection copies
    next_st.wr_sel  = new_sel;
    next_st.wr_ref  = new_ref;
    next_st.act_sel = use_sel;
    next_st.act_ref = use_ref;

    // Reference switches derived from the active code
    // Code 11 keeps the internal reference powered while it drives the pin
    next_st.ref_pin = (use_ref == `ACIS_REF_INT_PIN);
    next_st.int_ref = (use_ref == `ACIS_REF_INT) ||
                      (use_ref == `ACIS_REF_INT_PIN);
    next_st.ext_ref = (use_ref == `ACIS_REF_EXT);

    // Input routing from the decoder
    next_st.src     = dec_src;
    next_st.pos     = dec_pos;
    next_st.neg     = dec_neg;
    next_st.gain    = dec_gain;
    next_st.temp_en = (dec_src == acis_src_temp);

    // Mask register
    if (wr_mask) begin
      next_st.mask = reg_wdata[3:0];
    end

    // Status clears on read, then new events set on top
    if (rd_stat) begin
      next_st.stat = 4'h0;
    end
    if (conv_done) begin
      next_st.stat[`ACIS_EV_DONE] = 1'b1;
    end
    if ((use_sel != st.act_sel) || (use_ref != st.act_ref)) begin
      next_st.stat[`ACIS_EV_APPLY] = 1'b1;
    end
    if (next_st.abort) begin
      next_st.stat[`ACIS_EV_ABORT] = 1'b1;
    end
    // Code 11 is marked reserved yet wired up; tell software it was used
    if (wr_sel && (reg_wdata[7:6] == `ACIS_REF_INT_PIN)) begin
      next_st.stat[`ACIS_EV_RSVREF] = 1'b1;
    end
    next_st.irq = |(next_st.stat & next_st.mask);

    // Read data, valid only in the cycle after the strobe
    if (reg_rd) begin
      unique case (reg_addr)
        `ACIS_OFF_CSRA: begin
          next_st.rdata = {st.en, conv_busy, st.auto_bit, st.done_flag,
                           st.ie_bit, st.presc};
        end
        `ACIS_OFF_SEL: begin
          // Reads show the written copy, not the one in use
          next_st.rdata = {st.wr_ref, st.wr_sel};
        end
        `ACIS_OFF_STAT: begin
          next_st.rdata = {4'h0, st.stat};
        end
        `ACIS_OFF_MASK: begin
          next_st.rdata = {4'h0, st.mask};
        end
        // Unmapped addresses read as zero
        default: begin
          next_st.rdata = 8'h00;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from flops
  assign reg_rdata        = st.rdata;
  assign converter_enable = st.en;
  assign conv_abort       = st.abort;
  assign reference_select = st.act_ref;
  assign ref_pin_drive    = st.ref_pin;
  assign int_ref_on       = st.int_ref;
  assign ext_ref_sel      = st.ext_ref;
  assign input_select     = st.act_sel;
  assign src_kind         = st.src;
  assign pos_channel      = st.pos;
  assign neg_channel      = st.neg;
  assign gain_select_bit  = st.gain;
  assign temp_sensor_en   = st.temp_en;
  assign irq              = st.irq;

  // The settling wait after a new pair or reference is software's job; no timer here.

  // Checks
  sequence s_kill_write;
    wr_csra && converter_enable && !reg_wdata[`ACIS_CSRA_EN] && conv_busy && !conv_done;
  endsequence

  sequence s_one_pulse;
    conv_abort ##1 !conv_abort;
  endsequence

  enable_follows_a: assert property (@(posedge core_clk) disable iff (!resetn)
    wr_csra |=> converter_enable == $past(reg_wdata[`ACIS_CSRA_EN]))
    else $error("enable bit did not follow the write");

  abort_pulse_a: assert property (@(posedge core_clk) disable iff (!resetn)
    s_kill_write |=> s_one_pulse)
    else $error("abort pulse missing or too long");

  ref_hold_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (conv_busy && !conv_done) |=> reference_select == $past(reference_select))
    else $error("reference changed during a conversion");

  sel_hold_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (conv_busy && !conv_done) |=> input_select == $past(input_select))
    else $error("input changed during a conversion");

  done_apply_a: assert property (@(posedge core_clk) disable iff (!resetn)
    conv_done |=> st.done_flag && (input_select == st.wr_sel) &&
                  (reference_select == st.wr_ref))
    else $error("completion did not set flag or apply selection");

  ref_switch_a: assert property (@(posedge core_clk) disable iff (!resetn)
    ##1 (int_ref_on == reference_select[1]) &&
        (ext_ref_sel == (reference_select == `ACIS_REF_EXT)))
    else $error("reference switches disagree with code");

  ref_pin_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (wr_sel && !conv_busy && reg_wdata[7:6] == `ACIS_REF_INT_PIN)
      |=> ref_pin_drive ##1 (st.stat[`ACIS_EV_RSVREF] || $past(rd_stat)))
    else $error("code 11 did not drive the pin or flag");

  single_route_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (input_select[5:3] == 3'h0) |-> (src_kind == acis_src_single) &&
                                    (pos_channel == input_select[2:0]))
    else $error("single-ended code routed wrongly");

  temp_enable_a: assert property (@(posedge core_clk) disable iff (!resetn)
    temp_sensor_en == (input_select == `ACIS_SEL_TEMP))
    else $error("temperature sensor enable wrong");

  gain_bit_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (src_kind == acis_src_diff || src_kind == acis_src_calib)
      |-> gain_select_bit == input_select[0])
    else $error("gain does not follow lowest code bit");

  polarity_swap_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (src_kind == acis_src_diff && input_select[5] && !conv_busy && !wr_sel &&
     st.wr_sel == input_select)
      |=> pos_channel == $past(pos_channel))
    else $error("reversed pair unstable");

  calib_same_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (src_kind == acis_src_calib) |-> (pos_channel == neg_channel) &&
      (pos_channel == 3'h0 || pos_channel == 3'h3 || pos_channel == 3'h7))
    else $error("calibration code routed two pins");

  pair_first_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (input_select[5:1] == 5'h04) |-> (pos_channel == 3'h0) && (neg_channel == 3'h1))
    else $error("first pair decoded wrongly");

  irq_level_a: assert property (@(posedge core_clk) disable iff (!resetn)
    irq == |(st.stat & st.mask))
    else $error("interrupt level disagrees with status and mask");

  // Idle writes reach the active copies one edge later
  sequence s_idle_write;
    wr_sel && !conv_busy;
  endsequence

  sel_apply_idle_a: assert property (@(posedge core_clk) disable iff (!resetn)
    s_idle_write |=> (input_select == $past(reg_wdata[5:0])) &&
                     (reference_select == $past(reg_wdata[7:6])))
    else $error("idle write did not reach the active selection");

  // Concrete reversed pair: positive 1 against negative 0
  pair_swap_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (input_select[5:1] == 5'h14) |-> (pos_channel == 3'h1) && (neg_channel == 3'h0))
    else $error("reversed pair not swapped");

  // Pin 0 has only the high gain calibration code
  calib_zero_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (input_select == `ACIS_SEL_CAL0) |-> gain_select_bit && (pos_channel == 3'h0) &&
                                         (neg_channel == 3'h0))
    else $error("pin 0 calibration routed wrongly");

  // Supply reference must leave the pin and internal source alone
  ref_supply_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (reference_select == `ACIS_REF_VCC) |-> !int_ref_on && !ext_ref_sel && !ref_pin_drive)
    else $error("supply reference left another source on");

  // An abort pulse needs a disabling write during a conversion one edge earlier
  abort_cause_a: assert property (@(posedge core_clk) disable iff (!resetn)
    conv_abort |-> $past(wr_csra && !reg_wdata[`ACIS_CSRA_EN] && conv_busy && !conv_done) &&
                   $past(converter_enable))
    else $error("abort without a disabling write");

  // Writing one to the done bit clears it unless completion lands alongside
  done_clear_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (wr_csra && reg_wdata[`ACIS_CSRA_DONE] && !conv_done) |=> !st.done_flag)
    else $error("done flag survived its clear");

  // Sensor power only with the temperature channel routed
  temp_kind_a: assert property (@(posedge core_clk) disable iff (!resetn)
    temp_sensor_en |-> (src_kind == acis_src_temp))
    else $error("sensor powered for another source");

  // A status read empties the done event unless a new one arrives
  status_clear_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (rd_stat && !conv_done) |=> !st.stat[`ACIS_EV_DONE])
    else $error("status read did not clear the done event");

  // Read data stand one cycle only, so a stale value never looks fresh
  rdata_idle_a: assert property (@(posedge core_clk) disable iff (!resetn)
    !reg_rd |=> (reg_rdata == 8'h00))
    else $error("read data outside the read cycle");

endmodule

// ===== sim/acis_tb.sv
// Self-checking bench for the converter input and reference select block.
// Assumes the map header and package are compiled first; bench drives all ports itself.
`timescale 1ns/1ps
`include "acis_map.svh"

`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin mismatches++; \
  $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end

module testbench;
  import acis_pkg::*;

  // Clock, reset and register port
  logic        core_clk  = 1'b0;
  logic        resetn    = 1'b0;
  logic [7:0]  reg_addr  = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic [7:0]  reg_rdata;
  // Engine link and decoded outputs
  logic        conv_busy = 1'b0;
  logic        conv_done = 1'b0;
  logic        converter_enable, conv_abort, ref_pin_drive, int_ref_on, ext_ref_sel;
  logic [1:0]  reference_select;
  logic [5:0]  input_select;
  acis_src_t   src_kind;
  logic [2:0]  pos_channel, neg_channel;
  logic        gain_select_bit, temp_sensor_en, irq;
  // Bookkeeping
  int          mismatches = 0;
  int          cmp_count  = 0;
  integer      seed       = 32'hb520c01f;
  logic [7:0]  rd_val;
  logic [7:0]  sel_val;
  // Normal pair table, indexed by code bits 4:1; entries 0..3 unused
  logic [2:0]  pos_tab [0:15] = '{0, 0, 0, 0, 0, 0, 1, 1, 2, 3, 3, 3, 3, 4, 5, 6};
  logic [2:0]  neg_tab [0:15] = '{0, 0, 0, 0, 1, 3, 2, 3, 3, 4, 5, 6, 7, 5, 6, 7};

  acis_top u_dut (
    .core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .conv_busy(conv_busy),
    .conv_done(conv_done), .converter_enable(converter_enable), .conv_abort(conv_abort),
    .reference_select(reference_select), .ref_pin_drive(ref_pin_drive),
    .int_ref_on(int_ref_on), .ext_ref_sel(ext_ref_sel), .input_select(input_select),
    .src_kind(src_kind), .pos_channel(pos_channel), .neg_channel(neg_channel),
    .gain_select_bit(gain_select_bit), .temp_sensor_en(temp_sensor_en), .irq(irq)
  );

  // 125 MHz clock
  initial begin
    forever #4 core_clk = ~core_clk;
  end

  // Expected routing {kind, pos, neg, gain} for one input code
  function automatic logic [9:0] exp_route(input logic [5:0] c);
    acis_src_t  s;
    logic [2:0] p;
    logic [2:0] n;
    logic       g;
    s = acis_src_single;
    p = c[2:0];
    n = 3'h0;
    g = 1'b0;
    if (c[5:3] == 3'h0) s = acis_src_single;
    else if (c == `ACIS_SEL_AGND) s = acis_src_agnd;
    else if (c == `ACIS_SEL_IREF) s = acis_src_iref;
    else if (c == `ACIS_SEL_TEMP) s = acis_src_temp;
    else if (c[5:3] == 3'h4) begin
      // Calibration ties one pin to both inputs
      s = acis_src_calib;
      g = c[0];
      p = (c[2:1] == 2'h1) ? 3'h0 : (c[2:1] == 2'h2) ? 3'h3 : 3'h7;
      n = p;
    end else begin
      // Reversed pairs reuse the normal entry with pins swapped
      s = acis_src_diff;
      g = c[0];
      p = c[5] ? neg_tab[c[4:1]] : pos_tab[c[4:1]];
      n = c[5] ? pos_tab[c[4:1]] : neg_tab[c[4:1]];
    end
    return {s, p, n, g};
  endfunction

  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
    @(negedge core_clk);
  endtask

  // One-cycle read strobe; data taken in the following cycle only
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    @(negedge core_clk);
    d = reg_rdata;
  endtask

  // One-cycle completion pulse from the engine
  task automatic pulse_done();
    @(posedge core_clk);
    conv_done <= 1'b1;
    @(posedge core_clk);
    conv_done <= 1'b0;
    @(negedge core_clk);
  endtask

  // Compare every selection output against the written byte
  task automatic chk_sel(input logic [7:0] v);
    logic [9:0] e;
    e = exp_route(v[5:0]);
    `CHK(reference_select, v[7:6])
    `CHK(ext_ref_sel, v[7:6] == `ACIS_REF_EXT)
    `CHK(int_ref_on, v[7])
    `CHK(ref_pin_drive, v[7:6] == `ACIS_REF_INT_PIN)
    `CHK(input_select, v[5:0])
    `CHK(src_kind, e[9:7])
    `CHK(neg_channel, e[3:1])
    `CHK(gain_select_bit, e[0])
    `CHK(temp_sensor_en, v[5:0] == `ACIS_SEL_TEMP)
    // Ground, reference and temperature leave the positive pin unspecified
    if (e[9:7] != acis_src_agnd && e[9:7] != acis_src_iref && e[9:7] != acis_src_temp)
      `CHK(pos_channel, e[6:4])
  endtask

  // Verdict, reached by the main sequence and by the watchdog
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Watchdog: the sequence needs well under 3000 cycles
  initial begin
    repeat (20000) @(posedge core_clk);
    mismatches++;
    conclude();
  end

  // Main sequence
  initial begin
    repeat (5) @(posedge core_clk);
    resetn <= 1'b1;
    @(negedge core_clk);
    // Reset values and an unmapped place
    chk_sel(`ACIS_RST_SEL);
    `CHK(converter_enable, 1'b0)
    rd(`ACIS_OFF_CSRA, rd_val);
    `CHK(rd_val, `ACIS_RST_CSRA)
    rd(`ACIS_OFF_SEL, rd_val);
    `CHK(rd_val, `ACIS_RST_SEL)
    wr(8'h0a, 8'hff);
    rd(8'h0a, rd_val);
    `CHK(rd_val, 8'h00)
    // Every input code, then random bytes, while idle
    for (int i = 0; i < 96; i++) begin
      sel_val = (i < 64) ? {2'($random(seed)), 6'(i)} : 8'($random(seed));
      wr(`ACIS_OFF_SEL, sel_val);
      chk_sel(sel_val);
    end
    // Corner: reversed pair, then change during a conversion stays pending
    wr(`ACIS_OFF_SEL, 8'h2b);
    chk_sel(8'h2b);
    rd(`ACIS_OFF_STAT, rd_val);
    // Let the new reversed pair settle before the engine starts
    repeat (`ACIS_SETTLE_CYC * `ACIS_PRESC_DIV0) @(posedge core_clk);
    conv_busy <= 1'b1;
    wr(`ACIS_OFF_SEL, 8'hc9);
    repeat (3) @(negedge core_clk);
    chk_sel(8'h2b);
    rd(`ACIS_OFF_SEL, rd_val);
    `CHK(rd_val, 8'hc9)
    pulse_done();
    chk_sel(8'hc9);
    @(posedge core_clk);
    conv_busy <= 1'b0;
    rd(`ACIS_OFF_CSRA, rd_val);
    `CHK(rd_val[`ACIS_CSRA_DONE], 1'b1)
    rd(`ACIS_OFF_STAT, rd_val);
    `CHK(rd_val, 8'h0b)
    wr(`ACIS_OFF_CSRA, 8'h10);
    rd(`ACIS_OFF_CSRA, rd_val);
    `CHK(rd_val, 8'h00)
    // Plain storage bits read back as written, enable stays off
    wr(`ACIS_OFF_CSRA, 8'h2f);
    rd(`ACIS_OFF_CSRA, rd_val);
    `CHK(rd_val, 8'h2f)
    // Enable, then clear it during a conversion: one abort pulse
    wr(`ACIS_OFF_CSRA, 8'h80);
    `CHK(converter_enable, 1'b1)
    @(posedge core_clk);
    conv_busy <= 1'b1;
    wr(`ACIS_OFF_CSRA, 8'h00);
    `CHK(converter_enable, 1'b0)
    `CHK(conv_abort, 1'b1)
    @(negedge core_clk);
    `CHK(conv_abort, 1'b0)
    rd(`ACIS_OFF_CSRA, rd_val);
    `CHK(rd_val, 8'h40)
    rd(`ACIS_OFF_STAT, rd_val);
    `CHK(rd_val, 8'h04)
    @(posedge core_clk);
    conv_busy <= 1'b0;
    // Interrupt raised, cleared by read, then masked
    wr(`ACIS_OFF_MASK, 8'h01);
    rd(`ACIS_OFF_MASK, rd_val);
    `CHK(rd_val, 8'h01)
    pulse_done();
    @(negedge core_clk);
    `CHK(irq, 1'b1)
    rd(`ACIS_OFF_STAT, rd_val);
    `CHK(rd_val, 8'h01)
    @(negedge core_clk);
    `CHK(irq, 1'b0)
    wr(`ACIS_OFF_MASK, 8'h00);
    pulse_done();
    @(negedge core_clk);
    `CHK(irq, 1'b0)
    wr(`ACIS_OFF_MASK, 8'h01);
    @(negedge core_clk);
    `CHK(irq, 1'b1)
    conclude();
  end
endmodule
